// [rtl/monitor_dc_serial.sv]
`timescale 1ns/1ps
`include "mon_cfg.svh"
// Behaviour
// - offset filter is high-pass, bandwidth in control[5:2]
// - corner is fclk/2pi times 2^-(k+14)
// - k of 14 or 15 acts as 13
// - channel a and b offset readable in pairs
// - offset value is 14 bits full range
// - freeze stops estimate, last value still applied
// - unfreeze resumes estimate and applies it
// - control bit 0 feeds corrected samples to monitor
// - control bit 1 corrects main output data
// - serial port is master, outputs only
// - strobe and data change on clock rise
// - serial clock is adc clock /2, /4, /8
// - sleep stops serial clock when idle
// - strobe starts frame, datapath a then b
// - data msb first, after strobe edge
// - enabled results only: rms, peak, count
// - sync input restarts the monitor
// - sync passes through sample-clock synchroniser
// - peak is 13 bits, taken at period end
// - rms result is 20-bit fixed point
// - timer at one latches results, reloads period
module monitor_dc_serial #(
    parameter int DC_W = `DC_W,
    parameter int PERIOD_W = `PERIOD_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire mon_pkg::sample_t adc_a_in,
    input wire mon_pkg::sample_t adc_b_in,
    input wire logic sync_in,
    input wire logic [`ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [PERIOD_W-1:0] period_in,
    input wire logic [`THR_W-1:0] threshold_in,
    input wire logic rms_en_in,
    input wire logic peak_en_in,
    input wire logic thr_en_in,
    input wire logic [1:0] clk_rate_in,
    input wire logic clk_sleep_in,
    output mon_pkg::sample_t data_a_out,
    output mon_pkg::sample_t data_b_out,
    output logic monitor_serial_clock_out,
    output logic monitor_frame_strobe_out,
    output logic monitor_serial_out
);
    import mon_pkg::*;

    localparam int ACC_W = DC_W + `BW_BASE + 16;
    localparam int RMS_W = `RMS_W;
    localparam int PEAK_W = `PEAK_W;
    localparam int CNT_W = `CNT_W;
    localparam int SQ_W = `SQ_W;
    localparam int MS_W = `MS_W;
    localparam int LEN_W = `LEN_W;
    localparam int FIELDS_W = `FIELDS_W;
    localparam int WORD_W = LEN_W + FIELDS_W;

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdata_next;
    logic [3:0] bw_eff;
    logic [5:0] shift;
    logic sync_s1_reg;
    logic sync_s2_reg;
    logic sync_s3_reg;
    logic sync_rise;
    logic [PERIOD_W-1:0] timer_reg;
    logic [PERIOD_W-1:0] timer_next;
    logic period_done;
    logic restart;
    sample_t raw [2];
    sample_t corr [2];
    sample_t dc_val [2];
    logic [WORD_W-1:0] hold [2];
    logic [1:0] pend_reg;
    logic [1:0] pend_next;
    logic push_valid;
    logic push_ready;
    logic [WORD_W-1:0] push_data;
    logic pop_valid;
    logic pop;
    logic [WORD_W-1:0] pop_data;
    ser_state_t state_reg;
    ser_state_t state_next;
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic [2:0] half;
    logic run;
    logic sclk_next;
    logic fs_next;
    logic sdo_next;
    logic [FIELDS_W-1:0] sr_reg;
    logic [FIELDS_W-1:0] sr_next;
    logic [LEN_W-1:0] left_reg;
    logic [LEN_W-1:0] left_next;
    logic second_reg;
    logic second_next;

    // magnitude clipped to 13 bits; -8192 would need a 14th bit
    function automatic logic [PEAK_W-1:0] mag13(input sample_t s);
        logic [DC_W-1:0] a;
        a = s[DC_W-1] ? DC_W'(-s) : DC_W'(s);
        return a[DC_W-1] ? {PEAK_W{1'b1}} : a[PEAK_W-1:0];
    endfunction : mag13

    // left-align enabled fields, length in the top bits
    function automatic logic [WORD_W-1:0] pack(input logic [RMS_W-1:0] r, input logic [PEAK_W-1:0] p,
                                               input logic [CNT_W-1:0] c);
        logic [FIELDS_W-1:0] w;
        logic [LEN_W-1:0] n;
        w = '0;
        n = '0;
        if (rms_en_in) begin
            w = w | ({r, {(FIELDS_W-RMS_W){1'b0}}} >> n);
            n = n + LEN_W'(RMS_W);
        end
        if (peak_en_in) begin
            w = w | ({p, {(FIELDS_W-PEAK_W){1'b0}}} >> n);
            n = n + LEN_W'(PEAK_W);
        end
        if (thr_en_in) begin
            w = w | ({c, {(FIELDS_W-CNT_W){1'b0}}} >> n);
            n = n + LEN_W'(CNT_W);
        end
        return {n, w};
    endfunction : pack

    assign raw[0] = adc_a_in;
    assign raw[1] = adc_b_in;
    assign bw_eff = (ctrl_reg[`CTRL_BW_MSB:`CTRL_BW_LSB] > `BW_MAX) ? `BW_MAX
                  : ctrl_reg[`CTRL_BW_MSB:`CTRL_BW_LSB];
    assign shift = 6'(bw_eff) + 6'(`BW_BASE);
    assign sync_rise = sync_s2_reg && !sync_s3_reg;

    // register file: control write, offset readback
    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr_in && reg_addr_in == `OFS_CTRL) begin
            ctrl_next = reg_wdata_in;
        end
        unique case (reg_addr_in)
            `OFS_CTRL: rdata_next = ctrl_reg;
            `OFS_DCA_LO: rdata_next = dc_val[0][7:0];
            `OFS_DCA_HI: rdata_next = 8'(dc_val[0][DC_W-1:8]);
            `OFS_DCB_LO: rdata_next = dc_val[1][7:0];
            `OFS_DCB_HI: rdata_next = 8'(dc_val[1][DC_W-1:8]);
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= `CTRL_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            reg_rdata_out <= rdata_next;
        end
    end

    // two-stage synchroniser, third stage only for the edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_s1_reg <= 1'b0;
            sync_s2_reg <= 1'b0;
            sync_s3_reg <= 1'b0;
        end else begin
            sync_s1_reg <= sync_in;
            sync_s2_reg <= sync_s1_reg;
            sync_s3_reg <= sync_s2_reg;
        end
    end

    // period timer shared by both datapaths; zero means not yet loaded
    always_comb begin
        period_done = 1'b0;
        restart = sync_rise || timer_reg == '0;
        timer_next = timer_reg - PERIOD_W'(1);
        if (restart) begin
            timer_next = period_in;
        end else if (timer_reg == PERIOD_W'(1)) begin
            period_done = 1'b1;
            timer_next = period_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_reg <= '0;
        end else begin
            timer_reg <= timer_next;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [ACC_W-1:0] acc_reg;
        logic signed [ACC_W-1:0] acc_next;
        sample_t corr_sat;
        sample_t mon_smp;
        sample_t out_next;
        sample_t out_reg;
        logic signed [DC_W:0] diff;
        logic [PEAK_W-1:0] mag;
        logic [SQ_W-1:0] sq;
        logic over;
        logic [PEAK_W-1:0] peak_reg;
        logic [PEAK_W-1:0] peak_next;
        logic [MS_W-1:0] ms_reg;
        logic [MS_W-1:0] ms_next;
        logic [CNT_W-1:0] cnt_reg;
        logic [CNT_W-1:0] cnt_next;
        logic [WORD_W-1:0] hold_reg;
        logic [WORD_W-1:0] hold_next;

        // leaky integrator: dc tracks input at 2^-shift per sample
        assign dc_val[ch] = DC_W'(acc_reg >>> shift);
        assign diff = (DC_W+1)'(raw[ch]) - (DC_W+1)'(dc_val[ch]);
        // saturate so a large offset cannot wrap the output
        assign corr_sat = (diff[DC_W] != diff[DC_W-1]) ? {diff[DC_W], {(DC_W-1){!diff[DC_W]}}}
                        : diff[DC_W-1:0];
        assign corr[ch] = corr_sat;
        assign mon_smp = ctrl_reg[`CTRL_MON_EN] ? corr_sat : raw[ch];
        assign mag = mag13(mon_smp);
        assign sq = SQ_W'(mag) * SQ_W'(mag);
        assign over = mag > threshold_in;
        assign hold[ch] = hold_reg;

        // filter, output path and statistics
        always_comb begin
            acc_next = acc_reg + ACC_W'(raw[ch]) - ACC_W'(dc_val[ch]);
            if (ctrl_reg[`CTRL_FREEZE]) begin
                acc_next = acc_reg;
            end
            out_next = ctrl_reg[`CTRL_OUT_EN] ? corr_sat : raw[ch];
            peak_next = (mag > peak_reg) ? mag : peak_reg;
            ms_next = ms_reg + MS_W'(sq);
            cnt_next = cnt_reg + CNT_W'(over);
            hold_next = hold_reg;
            if (restart || period_done) begin
                peak_next = mag;
                ms_next = MS_W'(sq);
                cnt_next = CNT_W'(over);
            end
            if (period_done) begin
                hold_next = pack(ms_reg[MS_W-1 -: RMS_W], peak_reg, cnt_reg);
            end
        end

        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                acc_reg <= '0;
                out_reg <= '0;
                peak_reg <= '0;
                ms_reg <= '0;
                cnt_reg <= '0;
                hold_reg <= '0;
            end else begin
                acc_reg <= acc_next;
                out_reg <= out_next;
                peak_reg <= peak_next;
                ms_reg <= ms_next;
                cnt_reg <= cnt_next;
                hold_reg <= hold_next;
            end
        end
    end

    assign data_a_out = g_chan[0].out_reg;
    assign data_b_out = g_chan[1].out_reg;

    // push a then b; a full fifo stalls the push, new period wins
    always_comb begin
        push_valid = pend_reg != 2'h0;
        push_data = pend_reg[0] ? hold[0] : hold[1];
        pend_next = pend_reg;
        if (push_valid && push_ready) begin
            pend_next = pend_reg[0] ? {pend_reg[1], 1'b0} : 2'h0;
        end
        if (period_done && (rms_en_in || peak_en_in || thr_en_in)) begin
            pend_next = 2'h3;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg <= 2'h0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    mon_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(pop_valid),
        .out_ready_in(pop),
        .out_data_out(pop_data)
    );

    // half period minus one: rate 0,1,2 gives /2,/4,/8
    assign half = (clk_rate_in == 2'h0) ? 3'h0 : (clk_rate_in == 2'h1) ? 3'h1 : 3'h3;
    // lines must be back low before a sleeping clock may stop
    assign run = !clk_sleep_in || state_reg != SER_IDLE || pop_valid
              || monitor_frame_strobe_out || monitor_serial_out;

    // master serialiser; all line changes on the serial clock rise
    always_comb begin
        state_next = state_reg;
        div_next = div_reg + 3'h1;
        sclk_next = monitor_serial_clock_out;
        fs_next = monitor_frame_strobe_out;
        sdo_next = monitor_serial_out;
        sr_next = sr_reg;
        left_next = left_reg;
        second_next = second_reg;
        pop = 1'b0;
        if (!run && !monitor_serial_clock_out) begin
            div_next = 3'h0;
        end else if (div_reg == half) begin
            div_next = 3'h0;
            sclk_next = !monitor_serial_clock_out;
            if (!monitor_serial_clock_out) begin
                unique case (state_reg)
                    SER_IDLE: begin
                        fs_next = pop_valid;
                        sdo_next = 1'b0;
                        if (pop_valid) begin
                            pop = 1'b1;
                            {left_next, sr_next} = pop_data;
                            second_next = 1'b0;
                            state_next = SER_SHIFT;
                        end
                    end
                    SER_SHIFT: begin
                        fs_next = 1'b0;
                        sdo_next = sr_reg[FIELDS_W-1];
                        sr_next = sr_reg << 1;
                        left_next = left_reg - LEN_W'(1);
                        if (left_reg == LEN_W'(1)) begin
                            if (!second_reg && pop_valid) begin
                                pop = 1'b1;
                                {left_next, sr_next} = pop_data;
                                second_next = 1'b1;
                            end else begin
                                state_next = SER_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= SER_IDLE;
            div_reg <= 3'h0;
            monitor_serial_clock_out <= 1'b0;
            monitor_frame_strobe_out <= 1'b0;
            monitor_serial_out <= 1'b0;
            sr_reg <= '0;
            left_reg <= '0;
            second_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            monitor_serial_clock_out <= sclk_next;
            monitor_frame_strobe_out <= fs_next;
            monitor_serial_out <= sdo_next;
            sr_reg <= sr_next;
            left_reg <= left_next;
            second_reg <= second_next;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_freeze;
        ctrl_reg[`CTRL_FREEZE] |=> g_chan[0].acc_reg == $past(g_chan[0].acc_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("estimate moved while frozen");

    property p_bw_clamp;
        ctrl_reg[`CTRL_BW_MSB:`CTRL_BW_LSB] >= 4'hD |-> shift == 6'h1B;
    endproperty
    a_bw_clamp: assert property (p_bw_clamp) else $error("bandwidth not clamped");

    property p_out_corr;
        ctrl_reg[`CTRL_OUT_EN] |=> data_a_out == $past(corr[0]);
    endproperty
    a_out_corr: assert property (p_out_corr) else $error("output not corrected");

    property p_reload;
        timer_reg == 24'h000001 && !sync_rise |=> timer_reg == $past(period_in);
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not reload");

    property p_edge;
        $changed(monitor_serial_out) || $changed(monitor_frame_strobe_out) |-> $rose(monitor_serial_clock_out);
    endproperty
    a_edge: assert property (p_edge) else $error("line changed off clock rise");

    property p_sleep;
        clk_sleep_in && !run && !monitor_serial_clock_out |=> !monitor_serial_clock_out;
    endproperty
    a_sleep: assert property (p_sleep) else $error("clock ran while asleep");

    property p_rate;
        $changed(monitor_serial_clock_out) |-> $past(div_reg) == $past(half);
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock rate wrong");

    property p_msb;
        $fell(monitor_frame_strobe_out) |-> monitor_serial_out == $past(sr_reg[FIELDS_W-1]);
    endproperty
    a_msb: assert property (p_msb) else $error("first bit not msb");

    property p_sync;
        sync_rise |-> $past(sync_in, 2) && !$past(sync_in, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("sync not synchronised");

    property p_peak;
        period_done |=> g_chan[0].hold_reg != '0 || $past(g_chan[0].peak_reg) == '0 || !$past(peak_en_in);
    endproperty
    a_peak: assert property (p_peak) else $error("peak not latched");
endmodule : monitor_dc_serial

// [rtl/mon_cfg.svh]
`ifndef MON_CFG_SVH
`define MON_CFG_SVH
`define DC_W 14
`define BW_BASE 14
`define BW_MAX 4'hD
`define ADDR_W 9
`define OFS_CTRL 9'h10C
`define OFS_DCA_LO 9'h10D
`define OFS_DCA_HI 9'h10E
`define OFS_DCB_LO 9'h10F
`define OFS_DCB_HI 9'h110
`define CTRL_RESET 8'h00
`define CTRL_MON_EN 0
`define CTRL_OUT_EN 1
`define CTRL_BW_LSB 2
`define CTRL_BW_MSB 5
`define CTRL_FREEZE 6
`define PERIOD_W 24
`define THR_W 13
`define RMS_W 20
`define PEAK_W 13
`define CNT_W 24
`define SQ_W 26
`define MS_W 50
`define FIFO_DEPTH 4
`define LEN_W 6
`define FIELDS_W 57
`endif

// [rtl/mon_pkg.sv]
`include "mon_cfg.svh"
package mon_pkg;
    typedef logic signed [`DC_W-1:0] sample_t;
    typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;
endpackage : mon_pkg

// [rtl/mon_fifo.sv]
`timescale 1ns/1ps
module mon_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    // depth must be a power of two; pointers carry one wrap bit
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW:0] wr_reg;
    logic [PW:0] wr_next;
    logic [PW:0] rd_reg;
    logic [PW:0] rd_next;
    logic do_wr;
    logic do_rd;

    // honest flags from pointer compare
    assign in_ready_out = !((wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]));
    assign out_valid_out = (wr_reg != rd_reg);
    assign out_data_out = mem_reg[rd_reg[PW-1:0]];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    // pointer advance
    always_comb begin
        wr_next = do_wr ? wr_reg + (PW+1)'(1) : wr_reg;
        rd_next = do_rd ? rd_reg + (PW+1)'(1) : rd_reg;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage needs no reset, flags guard it
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem_reg[wr_reg[PW-1:0]] <= in_data_in;
        end
    end
endmodule : mon_fifo

// [bench/frame_rx.sv]
`timescale 1ns/1ps
module frame_rx (
    input wire logic sclk_in,
    input wire logic strobe_in,
    input wire logic sdo_in,
    input wire logic [6:0] nbits_in,
    output logic [113:0] bits_out,
    output logic [7:0] frames_out
);
    logic busy;
    logic [6:0] cnt;
    initial begin
        busy = 1'b0;
        cnt = 7'h00;
        bits_out = '0;
        frames_out = 8'h00;
    end
    // sample mid-bit on the fall, the port moves its lines on the rise
    always @(negedge sclk_in) begin
        if (strobe_in) begin
            busy = 1'b1;
            cnt = 7'h00;
            bits_out = '0;
        end else if (busy) begin
            bits_out = {bits_out[112:0], sdo_in};
            cnt = cnt + 7'h01;
            // >= so a length change mid-frame cannot hang the receiver
            if (cnt >= nbits_in) begin
                busy = 1'b0;
                frames_out = frames_out + 8'h01;
            end
        end
    end
endmodule : frame_rx

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "mon_cfg.svh"
module testbench;
    import mon_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    sample_t adc_a = '0, adc_b = '0, data_a, data_b;
    logic sync = 1'b0, wr = 1'b0, re_r = 1'b0, pe_r = 1'b1, te_r = 1'b1, sleep = 1'b0;
    logic sclk, strobe, sdo, rd_go = 1'b0, rd_seen;
    logic [`ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00, rdata, frames, seen = 8'h00;
    logic [12:0] thr = 13'h0000;
    logic [1:0] rate = 2'h0;
    logic [113:0] rx_bits;
    logic [15:0] lfsr_reg = 16'hE9FB;
    int fail_count = 0, checked = 0, cycles = 0, rises = 0;
    logic [7:0] rd_q[$];
    logic [113:0] fr_q[$];

    always #12.5 clk_in = ~clk_in;

    monitor_dc_serial DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .adc_a_in(adc_a), .adc_b_in(adc_b),
        .sync_in(sync), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .period_in(24'h000400), .threshold_in(thr), .rms_en_in(re_r), .peak_en_in(pe_r), .thr_en_in(te_r),
        .clk_rate_in(rate), .clk_sleep_in(sleep), .data_a_out(data_a), .data_b_out(data_b),
        .monitor_serial_clock_out(sclk), .monitor_frame_strobe_out(strobe), .monitor_serial_out(sdo));
    frame_rx rx (.sclk_in(sclk), .strobe_in(strobe), .sdo_in(sdo),
        .nbits_in(7'(40 * re_r + 26 * pe_r + 48 * te_r)), .bits_out(rx_bits), .frames_out(frames));

    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step
    function automatic logic [12:0] mag(input sample_t x);
        return 13'(x < 0 ? -x : x);
    endfunction : mag
    // per datapath: rms, peak then count, only those enabled, a then b
    function automatic logic [113:0] frame_exp(input logic [19:0] ra, rb, input logic [12:0] pa, pb,
                                               input logic [23:0] ca, cb, input logic re, pe, te);
        logic [113:0] f;
        f = '0;
        if (re) f = {f[93:0], ra};
        if (pe) f = {f[100:0], pa};
        if (te) f = {f[89:0], ca};
        if (re) f = {f[93:0], rb};
        if (pe) f = {f[100:0], pb};
        if (te) f = {f[89:0], cb};
        return f;
    endfunction : frame_exp

    task automatic finish_test();
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_frame(input logic [113:0] got, input logic [113:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_frame
    task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_in) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk_in) wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [8:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk_in) begin
            addr <= a;
            rd_go <= 1'b1;
        end
        @(posedge clk_in) rd_go <= 1'b0;
    endtask : reg_read
    // read data is registered, one cycle behind the address
    task automatic peek(input logic [8:0] a, output sample_t d);
        logic [7:0] lo;
        @(posedge clk_in) addr <= a;
        @(posedge clk_in) addr <= a + 9'h001;
        @(negedge clk_in) lo = rdata;
        @(posedge clk_in);
        @(negedge clk_in) d = sample_t'({rdata[5:0], lo});
    endtask : peek
    task automatic wait_frames(input int n);
        logic [7:0] t;
        t = frames + 8'(n);
        while (frames !== t) @(posedge clk_in);
    endtask : wait_frames

    // result watcher: oldest note against each read or frame
    always @(posedge clk_in) rd_seen <= rd_go;
    always @(negedge clk_in) begin
        if (rd_seen && rd_q.size() > 0) cmp_val(32'(rdata), 32'(rd_q.pop_front()));
        if (frames !== seen) begin
            seen = frames;
            if (fr_q.size() > 0) cmp_frame(rx_bits, fr_q.pop_front());
        end
    end
    always @(posedge sclk) rises++;
    // hang guard, well above the few tens of thousands of cycles needed
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        sample_t d1, d2, d3, xa, xb;
        logic [23:0] ca, cb;
        logic [19:0] ra, rb;
        int n0;
        time t0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        reg_read(`OFS_CTRL, `CTRL_RESET);
        reg_read(9'h111, 8'h00);
        reg_write(`OFS_DCA_LO, 8'hFF);
        reg_read(`OFS_DCA_LO, 8'h00);
        reg_read(`OFS_DCB_HI, 8'h00);
        reg_write(`OFS_CTRL, 8'hBF);
        reg_read(`OFS_CTRL, 8'hBF);
        @(posedge clk_in) sync <= 1'b1;
        @(posedge clk_in) sync <= 1'b0;
        // offset estimate with k=0 and output correction on
        xa = 14'sh0FA0;
        adc_a <= xa;
        reg_write(`OFS_CTRL, 8'h02);
        repeat (200) @(posedge clk_in);
        reg_write(`OFS_CTRL, 8'h42);
        peek(`OFS_DCA_LO, d1);
        repeat (100) @(posedge clk_in);
        peek(`OFS_DCA_LO, d2);
        cmp_val(32'(d2), 32'(d1));
        cmp_val(32'(data_a), 32'(sample_t'(xa - d1)));
        reg_write(`OFS_CTRL, 8'h02);
        repeat (100) @(posedge clk_in);
        peek(`OFS_DCA_LO, d3);
        cmp_val(32'(d3 != d1), 32'h1);
        reg_write(`OFS_CTRL, 8'h00);
        repeat (2) @(posedge clk_in);
        cmp_val(32'(data_a), 32'(xa));
        // reset in mid-run clears the estimate before the frame runs
        @(posedge clk_in) rst_n_in <= 1'b0;
        @(posedge clk_in) rst_n_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            lfsr_reg = lfsr_step(lfsr_reg);
            xa = sample_t'({lfsr_reg[12], lfsr_reg[12:0]});
            lfsr_reg = lfsr_step(lfsr_reg);
            xb = sample_t'({lfsr_reg[12], lfsr_reg[12:0]});
            @(posedge clk_in) begin
                adc_a <= xa;
                adc_b <= xb;
                thr <= {1'b0, lfsr_reg[15:4]};
                re_r <= (i != 3);
                pe_r <= (i != 2);
                te_r <= (i != 1);
                rate <= 2'(i);
                sleep <= i[0];
            end
            wait_frames(3);
            cmp_val(32'(data_b), 32'(xb));
            ca = (mag(xa) > thr) ? 24'h000400 : 24'h000000;
            cb = (mag(xb) > thr) ? 24'h000400 : 24'h000000;
            // mean-square top bits: 1024 equal squares land at bit 30 and up
            ra = 20'((32'(mag(xa)) * 32'(mag(xa))) >> 20);
            rb = 20'((32'(mag(xb)) * 32'(mag(xb))) >> 20);
            fr_q.push_back(frame_exp(ra, rb, mag(xa), mag(xb), ca, cb, re_r, pe_r, te_r));
            wait_frames(1);
            @(posedge strobe);
            @(posedge sclk);
            t0 = $time;
            @(posedge sclk);
            cmp_val(32'(($time - t0) / 25), (i == 0) ? 32'h2 : (i == 1) ? 32'h4 : 32'h8);
            wait_frames(1);
            repeat (20) @(posedge clk_in);
            n0 = rises;
            repeat (100) @(posedge clk_in);
            cmp_val(32'(rises != n0), 32'(!sleep));
            cmp_val(32'({strobe, sdo}), 32'h0);
        end
        finish_test();
    end
endmodule : testbench
